// >>> design/bwalu_addsub8.sv
// 8-bit adder/subtractor with carry, half-carry and overflow
module bwalu_addsub8 (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,      // carry (add) or borrow (sub) in
    input wire logic sub,      // 1 = a - b - cin
    output logic [7:0] sum,
    output logic cout,         // carry out, or borrow out on subtract
    output logic halfCarry,    // carry/borrow out of bit 3
    output logic ovf           // two's complement overflow
);
    logic [8:0] full; // nine-bit result for carry
    logic [4:0] low;  // low nibble result for half carry
    logic [7:0] bEff; // operand as seen by the adder
    // subtraction done as a + ~b + ~borrow
    always_comb begin
        bEff = sub ? ~b : b;
        full = {1'b0, a} + {1'b0, bEff} + {8'h00, cin ^ sub};
        low = {1'b0, a[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cin ^ sub};
        sum = full[7:0];
        cout = full[8] ^ sub;
        halfCarry = low[4] ^ sub;
        ovf = (a[7] == bEff[7]) && (sum[7] != a[7]);
    end
endmodule // bwalu_addsub8

// >>> design/bwalu_pkg.sv
// package: operation codes, flag layout and timing counts for the byte/word alu
package bwalu_pkg;
    // operation select from the decoder
    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_DIFF_REGS_WITH_BORROW, OP_DIFF_IMM, OP_DIFF_IMM_BORROW,
        OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
        OP_XOR, OP_SET_MASK, OP_CLEAR_MASK, OP_ZERO_NEG_CHECK, OP_ZERO_A_REG, OP_NOP
    } bwalu_op_t;
    // flag bit positions in the status byte
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_ALL_ONES = 8'hff;
    // clocks per operation class
    localparam int BYTE_OP_CLOCKS = 1;
    localparam int WORD_OP_CLOCKS = 2;
    // request from the decoder
    typedef struct packed {
        bwalu_op_t op;
        logic [7:0] dst;   // destination value (low byte for word ops)
        logic [7:0] dstHi; // high byte of the pair
        logic [7:0] src;   // source register value
        logic [7:0] imm;   // immediate constant
    } bwalu_req_t;
    // result back to the register file
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic wrLo;
        logic wrHi;
    } bwalu_res_t;
endpackage : bwalu_pkg

// >>> design/byte_word_alu.sv
// byte and word arithmetic/logic datapath with status flags
// Behaviour
// - add registers, optional carry, one clock
// - subtract registers, optional carry, one clock
// - subtract immediate from register, one clock
// - subtract immediate and carry, one clock
// - word pair plus immediate, two clocks
// - word pair minus immediate, two clocks
// - and with register or immediate
// - or with register or immediate
// - exclusive or of two registers
// - set mask bits by or
// - clear mask bits by and with complement
// - test register by anding with itself
// - clear register by xor with itself
module byte_word_alu (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,               // decoder presents an operation
    input wire bwalu_pkg::bwalu_req_t req,   // operation and operands
    output logic reqReady,                   // alu can take an operation
    output bwalu_pkg::bwalu_res_t res_ff,    // result towards the register file
    output logic resValid_ff,                // result write strobe
    output logic [7:0] flags_ff              // status flags
);
    // word operation phases
    typedef enum {WS_IDLE, WS_HIGH} bwalu_wstate_t;
    bwalu_wstate_t wState_ff;
    logic [7:0] wordHi_ff;  // latched high byte of the pair
    logic wordSub_ff;       // latched direction of the word op
    logic wordCarry_ff;     // carry from the low half
    logic [7:0] wordLo_ff;  // low result byte
    logic isWord;           // incoming op is a word op
    logic take;             // operation accepted this cycle
    logic [7:0] opA;
    logic [7:0] opB;
    logic cin;
    logic sub;
    logic [7:0] sum;
    logic cout;
    logic hc;
    logic ovf;
    logic [7:0] logicRes;   // logic unit result
    logic [7:0] nxt_flags;
    bwalu_pkg::bwalu_res_t nxt_res;
    logic nxt_valid;

    assign isWord = (req.op == bwalu_pkg::OP_WORD_PLUS_IMM) || (req.op == bwalu_pkg::OP_WORD_MINUS_IMM);
    assign reqReady = (wState_ff == WS_IDLE);
    assign take = reqValid && reqReady;

    // operand selection for the shared adder
    always_comb begin
        opA = req.dst;
        opB = req.src;
        cin = 1'b0;
        sub = 1'b0;
        if (wState_ff == WS_HIGH) begin
            // high half of the word: propagate carry or borrow only
            opA = wordHi_ff;
            opB = 8'h00;
            cin = wordCarry_ff;
            sub = wordSub_ff;
        end else begin
            case (req.op)
                bwalu_pkg::OP_ADC: cin = flags_ff[bwalu_pkg::FLAG_C];
                bwalu_pkg::OP_SUB: sub = 1'b1;
                bwalu_pkg::OP_DIFF_REGS_WITH_BORROW: begin
                    sub = 1'b1;
                    cin = flags_ff[bwalu_pkg::FLAG_C];
                end
                bwalu_pkg::OP_DIFF_IMM: begin
                    opB = req.imm;
                    sub = 1'b1;
                end
                bwalu_pkg::OP_DIFF_IMM_BORROW: begin
                    opB = req.imm;
                    sub = 1'b1;
                    cin = flags_ff[bwalu_pkg::FLAG_C];
                end
                bwalu_pkg::OP_WORD_PLUS_IMM: opB = req.imm;
                bwalu_pkg::OP_WORD_MINUS_IMM: begin
                    opB = req.imm;
                    sub = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    bwalu_addsub8 u_addsub (
        .a(opA),
        .b(opB),
        .cin(cin),
        .sub(sub),
        .sum(sum),
        .cout(cout),
        .halfCarry(hc),
        .ovf(ovf)
    );

    // logic unit
    always_comb begin
        case (req.op)
            bwalu_pkg::OP_AND: logicRes = req.dst & req.src;
            bwalu_pkg::OP_AND_IMM: logicRes = req.dst & req.imm;
            bwalu_pkg::OP_OR: logicRes = req.dst | req.src;
            bwalu_pkg::OP_OR_IMM: logicRes = req.dst | req.imm;
            bwalu_pkg::OP_XOR: logicRes = req.dst ^ req.src;
            bwalu_pkg::OP_SET_MASK: logicRes = req.dst | req.imm;
            bwalu_pkg::OP_CLEAR_MASK: logicRes = req.dst & (bwalu_pkg::MASK_ALL_ONES - req.imm);
            bwalu_pkg::OP_ZERO_NEG_CHECK: logicRes = req.dst & req.dst;
            bwalu_pkg::OP_ZERO_A_REG: logicRes = req.dst ^ req.dst;
            default: logicRes = 8'h00;
        endcase
    end

    // result, strobe and flag next values
    always_comb begin
        logic [15:0] word;
        word = {sum, wordLo_ff};
        nxt_flags = flags_ff;
        nxt_res = '0;
        nxt_valid = 1'b0;
        if (wState_ff == WS_HIGH) begin
            // second clock of a word op writes both bytes
            nxt_res.lo = wordLo_ff;
            nxt_res.hi = sum;
            nxt_res.wrLo = 1'b1;
            nxt_res.wrHi = 1'b1;
            nxt_valid = 1'b1;
            nxt_flags[bwalu_pkg::FLAG_Z] = (word == 16'h0000);
            nxt_flags[bwalu_pkg::FLAG_C] = cout;
            nxt_flags[bwalu_pkg::FLAG_N] = sum[7];
            nxt_flags[bwalu_pkg::FLAG_V] = wordSub_ff ? (wordHi_ff[7] & ~sum[7]) : (~wordHi_ff[7] & sum[7]);
            nxt_flags[bwalu_pkg::FLAG_S] = sum[7] ^ nxt_flags[bwalu_pkg::FLAG_V];
        end else if (take && !isWord && req.op != bwalu_pkg::OP_NOP) begin
            nxt_valid = 1'b1;
            nxt_res.wrLo = 1'b1;
            if (req.op <= bwalu_pkg::OP_DIFF_IMM_BORROW) begin
                nxt_res.lo = sum;
                nxt_flags[bwalu_pkg::FLAG_Z] = (sum == 8'h00);
                nxt_flags[bwalu_pkg::FLAG_C] = cout;
                nxt_flags[bwalu_pkg::FLAG_N] = sum[7];
                nxt_flags[bwalu_pkg::FLAG_V] = ovf;
                nxt_flags[bwalu_pkg::FLAG_H] = hc;
            end else begin
                nxt_res.lo = logicRes;
                nxt_flags[bwalu_pkg::FLAG_Z] = (logicRes == 8'h00);
                nxt_flags[bwalu_pkg::FLAG_N] = logicRes[7];
                nxt_flags[bwalu_pkg::FLAG_V] = 1'b0;
            end
        end
    end

    // word sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            wState_ff <= WS_IDLE;
        end else begin
            case (wState_ff)
                WS_IDLE: if (take && isWord) wState_ff <= WS_HIGH;
                WS_HIGH: wState_ff <= WS_IDLE;
                default: wState_ff <= WS_IDLE;
            endcase
        end
    end

    // low half capture of a word op
    always_ff @(posedge clk) begin
        if (rst) begin
            wordHi_ff <= 8'h00;
            wordLo_ff <= 8'h00;
            wordSub_ff <= 1'b0;
            wordCarry_ff <= 1'b0;
        end else if (take && isWord) begin
            wordHi_ff <= req.dstHi;
            wordLo_ff <= sum;
            wordSub_ff <= sub;
            wordCarry_ff <= cout;
        end
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            res_ff <= '0;
            resValid_ff <= 1'b0;
            flags_ff <= bwalu_pkg::FLAGS_RESET;
        end else begin
            res_ff <= nxt_res;
            resValid_ff <= nxt_valid;
            flags_ff <= nxt_flags;
        end
    end

    // checks
    a_byte_one_clock: assert property (@(posedge clk) disable iff (rst)
        take && !isWord && req.op != bwalu_pkg::OP_NOP |=> resValid_ff)
        else $error("byte op did not complete in one clock");
    a_word_two_clocks: assert property (@(posedge clk) disable iff (rst)
        take && isWord |=> !resValid_ff ##1 (resValid_ff && res_ff.wrHi))
        else $error("word op did not complete in two clocks");
    a_word_busy: assert property (@(posedge clk) disable iff (rst)
        take && isWord |=> !reqReady)
        else $error("alu ready during word high half");
    // word ops leave the half carry alone across both clocks
    a_word_keeps_h: assert property (@(posedge clk) disable iff (rst)
        take && isWord |-> ##2 flags_ff[bwalu_pkg::FLAG_H] == $past(flags_ff[bwalu_pkg::FLAG_H], 2))
        else $error("word op changed half carry");
    a_logic_h_kept: assert property (@(posedge clk) disable iff (rst)
        take && req.op >= bwalu_pkg::OP_AND && req.op <= bwalu_pkg::OP_ZERO_A_REG
        |=> flags_ff[bwalu_pkg::FLAG_H] == $past(flags_ff[bwalu_pkg::FLAG_H])
            && flags_ff[bwalu_pkg::FLAG_C] == $past(flags_ff[bwalu_pkg::FLAG_C]))
        else $error("logic op changed carry or half carry");
    a_logic_v_clear: assert property (@(posedge clk) disable iff (rst)
        take && req.op == bwalu_pkg::OP_AND |=> !flags_ff[bwalu_pkg::FLAG_V])
        else $error("and did not clear overflow");
    a_clear_reg: assert property (@(posedge clk) disable iff (rst)
        take && req.op == bwalu_pkg::OP_ZERO_A_REG |=> res_ff.lo == 8'h00 && flags_ff[bwalu_pkg::FLAG_Z])
        else $error("clear register wrong");
    a_test_keeps: assert property (@(posedge clk) disable iff (rst)
        take && req.op == bwalu_pkg::OP_ZERO_NEG_CHECK |=> res_ff.lo == $past(req.dst))
        else $error("test changed value");
    a_sub_imm: assert property (@(posedge clk) disable iff (rst)
        take && req.op == bwalu_pkg::OP_DIFF_IMM |=> res_ff.lo == 8'($past(req.dst) - $past(req.imm)))
        else $error("subtract immediate wrong");
    a_clear_mask: assert property (@(posedge clk) disable iff (rst)
        take && req.op == bwalu_pkg::OP_CLEAR_MASK |=> res_ff.lo == ($past(req.dst) & ~$past(req.imm)))
        else $error("clear mask wrong");
    c_word_op: cover property (@(posedge clk) take && isWord ##2 resValid_ff);
    c_borrow_chain: cover property (@(posedge clk)
        take && req.op == bwalu_pkg::OP_DIFF_REGS_WITH_BORROW && flags_ff[bwalu_pkg::FLAG_C]);
    c_zero_result: cover property (@(posedge clk) resValid_ff && flags_ff[bwalu_pkg::FLAG_Z]);
endmodule // byte_word_alu

// >>> test/bwalu_regfile_model.sv
// register file model that stores what the alu writes back
module bwalu_regfile_model (
    input wire logic clk,
    input wire logic rst,
    input wire bwalu_pkg::bwalu_res_t res,
    input wire logic resValid,
    output logic [7:0] pairLo_ff,
    output logic [7:0] pairHi_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    // each write strobe stores its own byte of the pair
    always_ff @(posedge clk) begin
        if (rst) begin
            pairLo_ff <= 8'h00;
            pairHi_ff <= 8'h00;
        end else if (resValid) begin
            if (res.wrLo) pairLo_ff <= res.lo;
            if (res.wrHi) pairHi_ff <= res.hi;
        end
    end
endmodule // bwalu_regfile_model

// >>> test/byte_word_alu_tb_top.sv
// self-checking bench for the byte/word alu
module byte_word_alu_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic reqValid = 1'h0;
    bwalu_pkg::bwalu_req_t req = '0;
    logic reqReady;
    bwalu_pkg::bwalu_res_t res;
    logic resValid;
    logic [7:0] flags;
    logic [7:0] pairLo;
    logic [7:0] pairHi;
    logic [7:0] expF = 8'h00; // predicted flags
    logic [7:0] expHi = 8'h00; // predicted stored high byte
    int num_errors = 0;
    int compares = 0;
    int cycles = 0; // hang guard count
    // 20 mhz clock
    always #25 clk = ~clk;
    byte_word_alu byte_word_alu_inst (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .res_ff(res), .resValid_ff(resValid), .flags_ff(flags));
    bwalu_regfile_model bwalu_regfile_model_inst (.clk(clk), .rst(rst), .res(res),
        .resValid(resValid), .pairLo_ff(pairLo), .pairHi_ff(pairHi));
    // compare and count
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // counts, verdict and end of run
    task automatic wrap_up;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            wrap_up;
        end
    end
    // issue one op, predict it, then judge timing, data and flags
    task automatic run(bwalu_pkg::bwalu_op_t op, logic [7:0] d, logic [7:0] b, logic [7:0] dh = 8'h00);
        logic w, sb, ar, im, ci;
        logic [7:0] x, y;
        logic [16:0] r;
        w = op inside {bwalu_pkg::OP_WORD_PLUS_IMM, bwalu_pkg::OP_WORD_MINUS_IMM};
        sb = op inside {bwalu_pkg::OP_SUB, bwalu_pkg::OP_DIFF_REGS_WITH_BORROW,
            bwalu_pkg::OP_DIFF_IMM, bwalu_pkg::OP_DIFF_IMM_BORROW};
        ar = sb || op inside {bwalu_pkg::OP_ADD, bwalu_pkg::OP_ADC};
        im = w || op inside {bwalu_pkg::OP_DIFF_IMM, bwalu_pkg::OP_DIFF_IMM_BORROW, bwalu_pkg::OP_AND_IMM,
            bwalu_pkg::OP_OR_IMM, bwalu_pkg::OP_SET_MASK, bwalu_pkg::OP_CLEAR_MASK};
        ci = expF[0] && op inside {bwalu_pkg::OP_ADC, bwalu_pkg::OP_DIFF_REGS_WITH_BORROW,
            bwalu_pkg::OP_DIFF_IMM_BORROW};
        // the unused operand field carries the inverse, so a wrong pick shows
        req = '{op, d, dh, im ? ~b : b, im ? b : ~b};
        if (op == bwalu_pkg::OP_CLEAR_MASK) b = 8'hff - b;
        if (op inside {bwalu_pkg::OP_ZERO_NEG_CHECK, bwalu_pkg::OP_ZERO_A_REG}) b = d;
        case (op)
            bwalu_pkg::OP_WORD_PLUS_IMM: r = {dh, d} + b;
            bwalu_pkg::OP_WORD_MINUS_IMM: r = {dh, d} - b;
            bwalu_pkg::OP_AND, bwalu_pkg::OP_AND_IMM,
            bwalu_pkg::OP_CLEAR_MASK, bwalu_pkg::OP_ZERO_NEG_CHECK: r = d & b;
            bwalu_pkg::OP_OR, bwalu_pkg::OP_OR_IMM, bwalu_pkg::OP_SET_MASK: r = d | b;
            bwalu_pkg::OP_XOR, bwalu_pkg::OP_ZERO_A_REG: r = d ^ b;
            default: r = sb ? d - b - ci : d + b + ci;
        endcase
        // subtract flags are the add equations on inverted minuend and result
        x = sb ? ~d : d;
        y = sb ? ~r[7:0] : r[7:0];
        if (w) begin
            expF[0] = r[16];
            expF[1] = r[15:0] == 16'h0000;
            expF[2] = r[15];
            expF[3] = (op == bwalu_pkg::OP_WORD_MINUS_IMM) ? dh[7] & ~r[15] : ~dh[7] & r[15];
            expF[4] = expF[2] ^ expF[3];
            expHi = r[15:8];
        end else begin
            expF[1] = r[7:0] == 8'h00;
            expF[2] = r[7];
            expF[3] = ar & ((x[7] & b[7] & ~y[7]) | (~x[7] & ~b[7] & y[7]));
            if (ar) begin
                expF[0] = r[8];
                expF[5] = (x[3] & b[3]) | (b[3] & ~y[3]) | (~y[3] & x[3]);
            end
        end
        @(negedge clk);
        reqValid = 1'h1;
        @(negedge clk);
        reqValid = 1'h0;
        check("strobe", {15'h0, !w}, {15'h0, resValid});
        if (w) begin
            check("ready", 16'h0000, {15'h0, reqReady});
            @(negedge clk);
            check("strobe", 16'h0001, {15'h0, resValid});
        end
        check("high write", {15'h0, w}, {15'h0, res.wrHi});
        check("flags", {8'h00, expF}, {8'h00, flags});
        @(negedge clk);
        check("stored pair", {expHi, r[7:0]}, {pairHi, pairLo});
    endtask
    // an idle operation is taken but writes nothing and leaves every flag
    task automatic t_nop;
        req = '{bwalu_pkg::OP_NOP, 8'h3c, 8'h3c, 8'h3c, 8'h3c};
        @(negedge clk);
        reqValid = 1'h1;
        @(negedge clk);
        reqValid = 1'h0;
        check("nop strobe", 16'h0000, {15'h0, resValid});
        check("nop flags", {8'h00, expF}, {8'h00, flags});
        @(negedge clk);
        // the last clear left the low byte at zero
        check("nop pair", {expHi, 8'h00}, {pairHi, pairLo});
    endtask
    // state right after reset
    task automatic t_reset;
        check("reset flags", {8'h00, bwalu_pkg::FLAGS_RESET}, {8'h00, flags});
        check("reset ready", 16'h0001, {15'h0, reqReady});
    endtask
    // register add, then add with the carry it left
    task automatic t_add;
        run(bwalu_pkg::OP_ADD, 8'h8f, 8'h81);
        run(bwalu_pkg::OP_ADC, 8'h0f, 8'h00);
    endtask
    // register subtract through zero, then with borrow
    task automatic t_sub;
        run(bwalu_pkg::OP_SUB, 8'h00, 8'h01);
        run(bwalu_pkg::OP_DIFF_REGS_WITH_BORROW, 8'h05, 8'h01);
    endtask
    // immediate subtract, then with borrow across the sign boundary
    task automatic t_imm;
        run(bwalu_pkg::OP_DIFF_IMM, 8'h00, 8'h01);
        run(bwalu_pkg::OP_DIFF_IMM_BORROW, 8'h80, 8'h00);
    endtask
    // word pair at its wrap and sign points
    task automatic t_word;
        run(bwalu_pkg::OP_WORD_PLUS_IMM, 8'hff, 8'h01, 8'hff);
        run(bwalu_pkg::OP_WORD_PLUS_IMM, 8'hff, 8'h3f, 8'h7f);
        run(bwalu_pkg::OP_WORD_MINUS_IMM, 8'h00, 8'h3f, 8'h80);
    endtask
    // every logic op, carry and half-carry left from before
    task automatic t_logic;
        run(bwalu_pkg::OP_AND, 8'hf0, 8'h3c);
        run(bwalu_pkg::OP_AND_IMM, 8'h0f, 8'hf0);
        run(bwalu_pkg::OP_OR, 8'h80, 8'h01);
        run(bwalu_pkg::OP_OR_IMM, 8'h00, 8'h00);
        run(bwalu_pkg::OP_XOR, 8'ha5, 8'h5a);
        run(bwalu_pkg::OP_SET_MASK, 8'h01, 8'h80);
        run(bwalu_pkg::OP_CLEAR_MASK, 8'hff, 8'h0f);
        run(bwalu_pkg::OP_ZERO_NEG_CHECK, 8'h80, 8'h00);
        run(bwalu_pkg::OP_ZERO_A_REG, 8'h5a, 8'h00);
    endtask
    // reset for 8 clocks, then the scenarios
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'h0;
        t_reset;
        t_add;
        t_sub;
        t_imm;
        t_word;
        t_logic;
        t_nop;
        wrap_up;
    end
endmodule // byte_word_alu_tb_top
